// File: common/clock_select_regs.svh
/*
 Offsets, field positions, reset values, encodings and counts of the
 system clock source selector. Assumes inclusion by bare name only.
*/
`ifndef CLOCK_SELECT_REGS_SVH
`define CLOCK_SELECT_REGS_SVH

// ********************************
// Register offsets (byte addresses)
// ********************************
`define OSC_CTRL_OFFSET 8'h00
`define OSC_STATUS_OFFSET 8'h04

// ********************************
// Control register fields
// ********************************
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 1
`define CTRL_MULT_BIT 4
`define CTRL_SOFT_EN_BIT 5
`define CTRL_RESET 8'h00

// ********************************
// Configuration oscillator field codes
// ********************************
`define CFG_LOW_GAIN_XTAL 3'h0
`define CFG_MID_GAIN_XTAL 3'h1
`define CFG_HIGH_GAIN_XTAL 3'h2
`define CFG_EXT_RC 3'h3
`define CFG_INTERNAL 3'h4
`define CFG_EXT_LOW 3'h5
`define CFG_EXT_MED 3'h6
`define CFG_EXT_HIGH 3'h7

// ********************************
// Amplifier gain codes
// ********************************
`define GAIN_OFF 2'h0
`define GAIN_LOW 2'h1
`define GAIN_MID 2'h2
`define GAIN_HIGH 2'h3

// ********************************
// Start-up count and bus answers
// ********************************
`define STARTUP_OSC_CYCLES 11'h400
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: common/clock_select_pkg.sv
/*
 Types of the system clock source selector.
 Assumes the constants of clock_select_regs.svh for field values.
*/
package clock_select_pkg;

   // ********************************
   // Configuration word straps
   // ********************************
   typedef struct packed {
      logic [2:0] osc_config_select;
      logic pll_config_enable;
      logic clock_out_enable;
      logic fail_safe_monitor;
      logic two_speed_enable;
      logic power_up_delay;
   } cfg_word_t;

   // ********************************
   // Sources and start-up states
   // ********************************
   typedef enum logic [1:0] {
      SRC_OSC_PIN = 2'b00,
      SRC_SECOND = 2'b01,
      SRC_FAST_INT = 2'b10,
      SRC_PLL = 2'b11
   } src_t;

   typedef enum logic [1:0] {
      ST_POWER_WAIT = 2'b00,
      ST_XTAL_COUNT = 2'b01,
      ST_RUN = 2'b10
   } start_state_t;

endpackage : clock_select_pkg

// File: hdl/system_clock_source_select.sv
/*
 System clock source selector with start-up counting, PLL control
 and an AXI4-Lite register slave.
 Assumes all inputs synchronous to aclk; oscillator inputs are sampled
 levels, so aclk must run well above any selected source.
*/
// Function
// - Config field 111/110/101 selects high, medium, low power external clock.
// - External clock mode skips the crystal start-up count entirely.
// - Stopped external clock holds all state; resumes exactly where stopped.
// - Crystal modes count 1024 oscillator input cycles before source is stable.
// - Start-up count begins after power-up delay expiry, and on wake.
// - Core is held during the start-up count unless fast start enabled.
// - With fail-safe or two-speed enabled, run from internal osc meanwhile.
// - Multiplier select bit set gives 3x PLL, cleared gives 4x.
// - PLL on if config bit or soft bit set; config bit overrides.
// - PLL output may be system clock from external or internal source.
// - Two-bit software select field picks external or internal source.
// - After reset the config oscillator field chooses the default source.
// - Software select can switch to secondary osc or configured source.
// - In external clock and RC modes, output pin is I/O or clock out.
// - Crystal modes apply low, medium, high amplifier gain respectively.
// - Config code 100 selects the internal oscillator block as default.
// - Select 00 uses configured clock; only path giving PLL internal osc.
`timescale 1ns/1ps
`include "clock_select_regs.svh"

module system_clock_source_select
   import clock_select_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [10:0] STARTUP_CYCLES = `STARTUP_OSC_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire cfg_word_t cfg_word,
   input wire logic power_up_expired,
   input wire logic wake_from_sleep,
   input wire logic osc_input_pin,
   input wire logic second_osc_in_pin,
   input wire logic fast_internal_osc,
   input wire logic pll_clk_in,
   input wire logic osc_output_pin_i,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   output logic osc_output_pin_o,
   output logic osc_output_pin_oe,
   output logic gpio_in,
   output logic sys_clk,
   output logic core_hold,
   output logic pll_enable,
   output logic pll_mult_3x,
   output logic [1:0] amp_gain
);

   // ********************************
   // Decoding helpers
   // ********************************
   function automatic logic is_crystal(input logic [2:0] code);
      is_crystal = (code == `CFG_LOW_GAIN_XTAL) || (code == `CFG_MID_GAIN_XTAL) ||
                   (code == `CFG_HIGH_GAIN_XTAL);
   endfunction : is_crystal

   function automatic logic is_ext_clock(input logic [2:0] code);
      is_ext_clock = (code == `CFG_EXT_HIGH) || (code == `CFG_EXT_MED) ||
                     (code == `CFG_EXT_LOW);
   endfunction : is_ext_clock

   function automatic src_t cfg_source(input logic [2:0] code, input logic pll);
      if (pll) begin
         cfg_source = SRC_PLL;
      end else if (code == `CFG_INTERNAL) begin
         cfg_source = SRC_FAST_INT;
      end else begin
         cfg_source = SRC_OSC_PIN;
      end
   endfunction : cfg_source

   // ********************************
   // State
   // ********************************
   cfg_word_t cfg_ff;
   logic [7:0] ctrl_ff;
   start_state_t state_ff;
   start_state_t nxt_state;
   logic [10:0] xtal_cnt_ff;
   logic [10:0] nxt_xtal_cnt;
   logic osc_prev_ff;
   src_t cur_src_ff;
   logic sys_clk_ff;
   logic core_hold_ff;
   logic pll_en_ff;
   logic mult_ff;
   logic [1:0] gain_ff;
   logic pin_o_ff;
   logic pin_oe_ff;
   logic gpio_in_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [1:0] bresp_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [7:0] wbyte_ff;
   logic wbyte_en_ff;

   // ********************************
   // Configuration decode
   // ********************************
   wire logic [1:0] sel_field = ctrl_ff[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
   wire logic cfg_crystal = is_crystal(cfg_ff.osc_config_select);
   wire logic cfg_ext = is_ext_clock(cfg_ff.osc_config_select);
   wire logic cfg_rc = (cfg_ff.osc_config_select == `CFG_EXT_RC);
   wire logic cfg_int = (cfg_ff.osc_config_select == `CFG_INTERNAL);
   wire logic fast_start = cfg_ff.fail_safe_monitor | cfg_ff.two_speed_enable;
   // Config bit forces the PLL on; soft bit only counts when it is clear
   wire logic pll_on = cfg_ff.pll_config_enable | ctrl_ff[`CTRL_SOFT_EN_BIT];
   wire logic [1:0] gain_sel =
      (cfg_ff.osc_config_select == `CFG_LOW_GAIN_XTAL) ? `GAIN_LOW :
      (cfg_ff.osc_config_select == `CFG_MID_GAIN_XTAL) ? `GAIN_MID :
      (cfg_ff.osc_config_select == `CFG_HIGH_GAIN_XTAL) ? `GAIN_HIGH :
      `GAIN_OFF;

   // ********************************
   // Start-up sequencing
   // ********************************
   // Edge counting stalls when the pin stops; nothing times out, so a
   // halted external clock simply freezes the sequence in place
   wire logic osc_rise = osc_input_pin & ~osc_prev_ff;
   wire logic xtal_last = osc_rise && (xtal_cnt_ff == STARTUP_CYCLES - 11'h001);

   always_comb begin
      nxt_state = state_ff;
      nxt_xtal_cnt = xtal_cnt_ff;
      case (state_ff)
         ST_POWER_WAIT: begin
            if (!cfg_ff.power_up_delay || power_up_expired) begin
               nxt_state = cfg_crystal ? ST_XTAL_COUNT : ST_RUN;
               nxt_xtal_cnt = 11'h000;
            end
         end
         ST_XTAL_COUNT: begin
            if (xtal_last) begin
               nxt_state = ST_RUN;
            end else if (osc_rise) begin
               nxt_xtal_cnt = xtal_cnt_ff + 11'h001;
            end
         end
         ST_RUN: begin
            if (wake_from_sleep && cfg_crystal) begin
               nxt_state = ST_XTAL_COUNT;
               nxt_xtal_cnt = 11'h000;
            end
         end
         default: begin
            nxt_state = ST_POWER_WAIT;
         end
      endcase
   end

   // ********************************
   // Source choice
   // ********************************
   // Select 00 follows the config field; PLL reaches the internal osc
   // only here, 1x always means the bare internal oscillator
   wire src_t cfg_src = cfg_source(cfg_ff.osc_config_select, pll_on);
   wire src_t soft_src = (sel_field == 2'h0) ? cfg_src :
                         (sel_field == 2'h1) ? SRC_SECOND : SRC_FAST_INT;
   wire src_t want_src = (state_ff == ST_XTAL_COUNT) ? SRC_FAST_INT : soft_src;
   // Reset lands on the strap's own source, so no switch follows release except to the internal osc for a crystal start-up count
   wire src_t reset_src = cfg_source(cfg_word.osc_config_select, cfg_word.pll_config_enable);
   wire logic [3:0] src_lvl = {pll_clk_in, fast_internal_osc, second_osc_in_pin,
                               osc_input_pin};
   // Trades a few cycles of switch latency for a glitch-free handover
   wire logic safe_switch = !src_lvl[cur_src_ff] && !src_lvl[want_src];
   wire logic hold_now = (nxt_state == ST_POWER_WAIT) ||
                         ((nxt_state == ST_XTAL_COUNT) && !fast_start);

   // ********************************
   // Output pin function
   // ********************************
   wire logic pin_free = cfg_ext | cfg_rc | cfg_int;
   wire logic clkout_sel = pin_free & cfg_ff.clock_out_enable;
   wire logic nxt_pin_o = clkout_sel ? sys_clk_ff : gpio_out;
   wire logic nxt_pin_oe = clkout_sel | (pin_free & gpio_oe);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= cfg_word;
         state_ff <= ST_POWER_WAIT;
         xtal_cnt_ff <= 11'h000;
         osc_prev_ff <= 1'b0;
         cur_src_ff <= reset_src;
      end else begin
         state_ff <= nxt_state;
         xtal_cnt_ff <= nxt_xtal_cnt;
         osc_prev_ff <= osc_input_pin;
         if (want_src != cur_src_ff && safe_switch) begin
            cur_src_ff <= want_src;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_clk_ff <= 1'b0;
         core_hold_ff <= 1'b1;
         pll_en_ff <= 1'b0;
         mult_ff <= 1'b0;
         gain_ff <= `GAIN_OFF;
         pin_o_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
         gpio_in_ff <= 1'b0;
      end else begin
         sys_clk_ff <= src_lvl[cur_src_ff];
         core_hold_ff <= hold_now;
         pll_en_ff <= pll_on;
         mult_ff <= ctrl_ff[`CTRL_MULT_BIT];
         gain_ff <= gain_sel;
         pin_o_ff <= nxt_pin_o;
         pin_oe_ff <= nxt_pin_oe;
         gpio_in_ff <= osc_output_pin_i;
      end
   end

   // ********************************
   // AXI4-Lite write channel
   // ********************************
   wire logic aw_take = awvalid & awready_ff;
   wire logic w_take = wvalid & wready_ff;
   wire logic aw_have = aw_take | ~awready_ff;
   wire logic w_have = w_take | ~wready_ff;
   wire logic [ADDR_W-1:0] waddr_now = aw_take ? awaddr : waddr_ff;
   wire logic wr_go = aw_have & w_have & ~bvalid_ff;
   wire logic wr_hit = (waddr_now == `OSC_CTRL_OFFSET);
   wire logic wr_ro = (waddr_now == `OSC_STATUS_OFFSET);
   wire logic [7:0] wbyte_now = w_take ? wdata[7:0] : wbyte_ff;
   wire logic wbyte_en_now = w_take ? wstrb[0] : wbyte_en_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
         waddr_ff <= '0;
         wbyte_ff <= 8'h00;
         wbyte_en_ff <= 1'b0;
         ctrl_ff <= `CTRL_RESET;
      end else begin
         if (aw_take) begin
            awready_ff <= 1'b0;
            waddr_ff <= awaddr;
         end
         if (w_take) begin
            wready_ff <= 1'b0;
            wbyte_ff <= wdata[7:0];
            wbyte_en_ff <= wstrb[0];
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_hit || wr_ro) ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_hit && wbyte_en_now) begin
               ctrl_ff <= wbyte_now & 8'h33;
            end
         end
         if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // ********************************
   // AXI4-Lite read channel
   // ********************************
   wire logic [31:0] status_word = {21'h000000, cfg_ff.osc_config_select, gain_ff,
                                    mult_ff, pll_en_ff, core_hold_ff,
                                    (state_ff == ST_RUN), cur_src_ff};
   wire logic [31:0] ctrl_word = {24'h000000, ctrl_ff};
   wire logic rd_ctrl = (araddr == `OSC_CTRL_OFFSET);
   wire logic rd_status = (araddr == `OSC_STATUS_OFFSET);
   wire logic [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_status ? status_word : 32'h00000000);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `RESP_OKAY;
      end else begin
         if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= (rd_ctrl || rd_status) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // ********************************
   // Outputs
   // ********************************
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign sys_clk = sys_clk_ff;
   assign core_hold = core_hold_ff;
   assign pll_enable = pll_en_ff;
   assign pll_mult_3x = mult_ff;
   assign amp_gain = gain_ff;
   assign osc_output_pin_o = pin_o_ff;
   assign osc_output_pin_oe = pin_oe_ff;
   assign gpio_in = gpio_in_ff;

endmodule : system_clock_source_select

// File: testbench/osc_partner_model.sv
/*
 Far-side clock sources: oscillator pin, secondary, fast internal, PLL.
 Assumes aclk runs well above every source; run low stops them all.
*/
`timescale 1ns/1ps
module osc_partner_model (
   input wire logic aclk,
   input wire logic run,
   output logic osc_input_pin,
   output logic second_osc_in_pin,
   output logic fast_internal_osc,
   output logic pll_clk_in
);
   logic [3:0] cnt_ff = 4'h0;
   // A halted source keeps its level, like a stopped clock
   always_ff @(posedge aclk) begin
      if (run) begin
         cnt_ff <= (cnt_ff == 4'hB) ? 4'h0 : cnt_ff + 4'h1;
      end
   end
   // Phases chosen so that every pair of sources is low together at times
   assign osc_input_pin = cnt_ff[1];
   assign fast_internal_osc = cnt_ff[0];
   assign pll_clk_in = cnt_ff[1] ^ cnt_ff[0];
   assign second_osc_in_pin = (cnt_ff >= 4'h3 && cnt_ff < 4'h6) || cnt_ff >= 4'h9;
endmodule : osc_partner_model

// File: testbench/system_clock_source_select_asserts.sv
/*
 Concurrent checks on the selector's ports.
 Assumes straps change only while reset is held.
*/
`timescale 1ns/1ps
`include "clock_select_regs.svh"
module system_clock_source_select_asserts
   import clock_select_pkg::*;
#(
   parameter logic [10:0] STARTUP_CYCLES = `STARTUP_OSC_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire cfg_word_t cfg_word,
   input wire logic osc_input_pin,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   input wire logic osc_output_pin_o,
   input wire logic osc_output_pin_oe,
   input wire logic sys_clk,
   input wire logic core_hold,
   input wire logic pll_enable,
   input wire logic [1:0] amp_gain
);
   logic [2:0] rst_sh_ff;
   logic osc_d_ff;
   logic [10:0] edges_ff;
   logic xtal, quick, pud, settled, rise;
   logic [1:0] gain_exp;
   assign xtal = cfg_word.osc_config_select < 3'h3;
   assign quick = cfg_word.fail_safe_monitor | cfg_word.two_speed_enable;
   assign pud = cfg_word.power_up_delay;
   assign settled = &rst_sh_ff;
   assign rise = rst_sh_ff[0] && osc_input_pin && !osc_d_ff;
   assign gain_exp = xtal ? cfg_word.osc_config_select[1:0] + 2'h1 : 2'h0;
   // Edges seen while held, including the edge that ends the hold
   always_ff @(posedge aclk) begin
      rst_sh_ff <= {rst_sh_ff[1:0], aresetn};
      osc_d_ff <= osc_input_pin;
      edges_ff <= (aresetn && core_hold) ? edges_ff + 11'(rise) : 11'h000;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ********************************
   // Properties
   // ********************************
   property p_pll_cfg;
      settled && cfg_word.pll_config_enable |-> pll_enable;
   endproperty
   a_pll_cfg: assert property (p_pll_cfg) else $error("pll off with strap set");
   property p_amp_gain;
      settled |-> amp_gain == gain_exp;
   endproperty
   a_amp_gain: assert property (p_amp_gain) else $error("wrong amplifier gain");
   property p_ext_no_hold;
      settled && !xtal && !pud |-> !core_hold;
   endproperty
   a_ext_no_hold: assert property (p_ext_no_hold) else $error("held without count");
   property p_ost_count;
      $fell(core_hold) && xtal && !quick && !pud |-> edges_ff == STARTUP_CYCLES;
   endproperty
   a_ost_count: assert property (p_ost_count) else $error("start count wrong");
   property p_fast_start;
      settled && xtal && quick && !pud |-> !core_hold;
   endproperty
   a_fast_start: assert property (p_fast_start) else $error("held in fast start");
   property p_pin_clkout;
      settled && !xtal && cfg_word.clock_out_enable |-> osc_output_pin_oe &&
         (osc_output_pin_o == sys_clk || osc_output_pin_o == $past(sys_clk));
   endproperty
   a_pin_clkout: assert property (p_pin_clkout) else $error("no clock out");
   property p_pin_gpio;
      settled && !xtal && !cfg_word.clock_out_enable |->
         osc_output_pin_oe == $past(gpio_oe) && osc_output_pin_o == $past(gpio_out);
   endproperty
   a_pin_gpio: assert property (p_pin_gpio) else $error("pin not general io");
   property p_xtal_oe;
      settled && xtal |-> !osc_output_pin_oe;
   endproperty
   a_xtal_oe: assert property (p_xtal_oe) else $error("crystal pin driven");
   c_ost_done: cover property ($fell(core_hold));
   c_clkout: cover property (osc_output_pin_oe && sys_clk);
   c_pll: cover property (pll_enable);
endmodule : system_clock_source_select_asserts

bind system_clock_source_select system_clock_source_select_asserts #(
   .STARTUP_CYCLES(STARTUP_CYCLES)
) chk (
   .aclk, .aresetn, .cfg_word, .osc_input_pin, .gpio_out, .gpio_oe, .osc_output_pin_o,
   .osc_output_pin_oe, .sys_clk, .core_hold, .pll_enable, .amp_gain
);

// File: testbench/system_clock_source_select_test.sv
/*
 Directed bench for the clock source selector.
 Assumes the far-side model and the bound checker; short start count.
*/
`timescale 1ns/1ps
`include "clock_select_regs.svh"
module system_clock_source_select_test
   import clock_select_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, run = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata;
   cfg_word_t cfg_word = 8'h00;
   logic power_up_expired = 1'h1, wake_from_sleep = 1'h0, gpio_out = 1'h0, gpio_oe = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, osc_output_pin_o, osc_output_pin_oe;
   logic gpio_in, sys_clk, core_hold, pll_enable, pll_mult_3x, pin_lvl;
   logic osc_input_pin, second_osc_in_pin, fast_internal_osc, pll_clk_in;
   logic [1:0] bresp, rresp, amp_gain;
   int failures = 0, n_checks = 0;
   // Pin pulled up when nobody drives it
   assign pin_lvl = osc_output_pin_oe ? osc_output_pin_o : 1'h1;
   always #5 aclk = ~aclk;
   system_clock_source_select #(.STARTUP_CYCLES(11'h008)) uut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .cfg_word, .power_up_expired, .wake_from_sleep, .osc_input_pin,
      .second_osc_in_pin, .fast_internal_osc, .pll_clk_in, .osc_output_pin_i(pin_lvl),
      .gpio_out, .gpio_oe, .osc_output_pin_o, .osc_output_pin_oe, .gpio_in, .sys_clk,
      .core_hold, .pll_enable, .pll_mult_3x, .amp_gain
   );
   osc_partner_model far (.aclk, .run, .osc_input_pin, .second_osc_in_pin,
      .fast_internal_osc, .pll_clk_in);
   // ********************************
   // Shared tasks
   // ********************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, w, got, exp);
      end
   endtask : chk
   task automatic limit(input int i, input int lim);
      if (i >= lim) begin
         failures++;
         $display("MISMATCH %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask : limit
   // Values read right after an edge are those the edge sampled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      limit(i, 50);
      bready <= 1'h0;
      chk(32'(bresp), 32'(er), "bresp");
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      limit(i, 50);
      d = rdata;
      rready <= 1'h0;
      chk(32'(rresp), 32'(er), "rresp");
   endtask : rd
   task automatic do_reset(input cfg_word_t c);
      @(posedge aclk);
      aresetn <= 1'h0;
      cfg_word <= c;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
   endtask : do_reset
   task automatic hold_is(input logic v);
      int i;
      for (i = 0; i < 300 && core_hold !== v; i++) @(posedge aclk);
      limit(i, 300);
   endtask : hold_is
   task automatic src_is(input logic [1:0] e);
      logic [31:0] s;
      for (int i = 0; i < 20; i++) begin
         rd(`OSC_STATUS_OFFSET, s, `RESP_OKAY);
         if (s[1:0] === e) break;
      end
      chk(32'(s[1:0]), 32'(e), "source");
   endtask : src_is
   // ********************************
   // Scenarios
   // ********************************
   task automatic t_modes();
      logic [31:0] s;
      for (int m = 3; m < 8; m++) begin
         do_reset({3'(m), 5'h08});
         rd(`OSC_STATUS_OFFSET, s, `RESP_OKAY);
         rd(`OSC_STATUS_OFFSET, s, `RESP_OKAY);
         chk(s, {21'h0, 3'(m), 6'h01, (m == 4) ? 2'h2 : 2'h0}, "mode");
      end
   endtask : t_modes
   task automatic t_xtal();
      logic [31:0] s;
      for (int m = 0; m < 3; m++) begin
         do_reset({3'(m), 5'h00});
         repeat (3) @(posedge aclk);
         chk(32'(core_hold), 32'h1, "held");
         chk(32'(amp_gain), 32'(m + 1), "gain");
         hold_is(1'h0);
      end
      wake_from_sleep <= 1'h1;
      @(posedge aclk);
      wake_from_sleep <= 1'h0;
      repeat (2) @(posedge aclk);
      chk(32'(core_hold), 32'h1, "wake");
      hold_is(1'h0);
      power_up_expired <= 1'h0;
      do_reset({3'h1, 5'h01});
      repeat (60) @(posedge aclk);
      chk(32'(core_hold), 32'h1, "delay");
      power_up_expired <= 1'h1;
      hold_is(1'h0);
      do_reset({3'h2, 5'h04});
      src_is(2'h2);
      rd(`OSC_STATUS_OFFSET, s, `RESP_OKAY);
      chk(32'(s[3:0]), 32'h2, "fast start");
   endtask : t_xtal
   task automatic t_regs();
      logic [31:0] s;
      logic c;
      do_reset({3'h7, 5'h00});
      gpio_oe <= 1'h1;
      repeat (3) @(posedge aclk);
      chk(32'({osc_output_pin_oe, osc_output_pin_o, gpio_in}), 32'h4, "gpio");
      gpio_out <= 1'h1;
      gpio_oe <= 1'h0;
      repeat (3) @(posedge aclk);
      chk(32'({osc_output_pin_oe, osc_output_pin_o, gpio_in}), 32'h3, "pull-up");
      rd(`OSC_CTRL_OFFSET, s, `RESP_OKAY);
      chk(s, 32'h0, "ctrl reset");
      rd(8'h08, s, `RESP_SLVERR);
      wr(8'h0C, 32'h3, `RESP_SLVERR);
      wr(`OSC_STATUS_OFFSET, 32'hFF, `RESP_OKAY);
      wr(`OSC_CTRL_OFFSET, 32'h1, `RESP_OKAY);
      src_is(2'h1);
      wr(`OSC_CTRL_OFFSET, 32'h2, `RESP_OKAY);
      src_is(2'h2);
      wr(`OSC_CTRL_OFFSET, 32'h30, `RESP_OKAY);
      src_is(2'h3);
      chk(32'({pll_enable, pll_mult_3x}), 32'h3, "pll 3x");
      wr(`OSC_CTRL_OFFSET, 32'h20, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'({pll_enable, pll_mult_3x}), 32'h2, "pll 4x");
      wr(`OSC_CTRL_OFFSET, 32'hFF, `RESP_OKAY);
      rd(`OSC_CTRL_OFFSET, s, `RESP_OKAY);
      chk(s, 32'h33, "ctrl bits");
      wr(`OSC_CTRL_OFFSET, 32'h0, `RESP_OKAY);
      src_is(2'h0);
      run <= 1'h0;
      repeat (4) @(posedge aclk);
      c = sys_clk;
      repeat (20) @(posedge aclk);
      chk(32'(sys_clk), 32'(c), "static");
      run <= 1'h1;
      rd(`OSC_STATUS_OFFSET, s, `RESP_OKAY);
      chk(s, {21'h0, 3'h7, 6'h01, 2'h0}, "resume");
   endtask : t_regs
   task automatic t_strap();
      do_reset({3'h4, 5'h10});
      wr(`OSC_CTRL_OFFSET, 32'h0, `RESP_OKAY);
      src_is(2'h3);
      chk(32'(pll_enable), 32'h1, "strap");
   endtask : t_strap
   initial begin
      t_modes();
      t_xtal();
      t_regs();
      t_strap();
      tally_and_finish();
   end
endmodule : system_clock_source_select_test
